// file: rtl/ddr2_pin_pkg.sv
package ddr2_pin_pkg;

	// Pin widths of one channel
	localparam int CLK_PAIRS   = 6;	// Three clock pairs per module
	localparam int RANKS       = 4;	// One select, enable, termination per rank
	localparam int ADDR_W      = 14;	// Multiplexed row and column address
	localparam int BANK_W      = 3;	// Eight banks
	localparam int DQ_W        = 64;	// Data lines
	localparam int LANES       = 8;	// Byte lanes, masks and strobe pairs
	localparam int HALF_W      = DQ_W;	// One beat per clock edge of the link

	// Values after reset
	localparam logic [RANKS-1:0]  RST_SEL_N = 4'hf;	// No rank selected
	localparam logic [RANKS-1:0]  RST_CKE   = 4'h0;	// Ranks held in power-down
	localparam logic [RANKS-1:0]  RST_ODT   = 4'h0;	// Termination off
	localparam logic [ADDR_W-1:0] RST_ADDR  = 14'h0000;
	localparam logic [BANK_W-1:0] RST_BANK  = 3'h0;

	// Clock divider: memory clock is mclk divided by 2*CLK_HALF_CYC
	localparam logic [1:0] CLK_HALF_CYC = 2'h2;

	// Command encodings, row/col/we active low
	typedef enum logic [2:0] {
		CMD_MRS   = 3'h0,	// Mode register set
		CMD_REF   = 3'h1,	// Refresh, self-refresh with clock enable low
		CMD_PRE   = 3'h2,	// Precharge
		CMD_ACT   = 3'h3,	// Activate
		CMD_WR    = 3'h4,	// Write
		CMD_RD    = 3'h5,	// Read
		CMD_NOP   = 3'h7	// No operation
	} cmd_t;

	// Command request from the controller core
	typedef struct packed {
		logic              valid;	// Issue this command
		cmd_t              cmd;	// Command to encode
		logic [1:0]        rank;	// Addressed rank
		logic [BANK_W-1:0] bank;	// Bank within the rank
		logic [ADDR_W-1:0] addr;	// Row or column address
	} cmd_req_t;

	// Write data for one memory clock: rising then falling half
	typedef struct packed {
		logic              valid;	// Drive data this clock
		logic [DQ_W-1:0]   rise_d;	// Beat on rising strobe
		logic [DQ_W-1:0]   fall_d;	// Beat on falling strobe
		logic [LANES-1:0]  rise_m;	// Byte masks of rising beat
		logic [LANES-1:0]  fall_m;	// Byte masks of falling beat
	} wr_beat_t;

	// Read data captured from the memory
	typedef struct packed {
		logic            valid;	// Pair of beats captured
		logic [DQ_W-1:0] rise_d;	// Beat at strobe rise
		logic [DQ_W-1:0] fall_d;	// Beat at strobe fall
	} rd_beat_t;

endpackage : ddr2_pin_pkg

// file: rtl/ddr2_chan.sv
`timescale 1ns/100ps
// One channel: clock, command, data, mask, strobe, enable, termination pins
module ddr2_chan
	import ddr2_pin_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// Controller side
	input  wire cmd_req_t          req,
	input  wire wr_beat_t          wr,
	input  wire logic [RANKS-1:0]  cke_req,
	input  wire logic [RANKS-1:0]  odt_req,
	input  wire logic              rd_en,
	output logic                   clk_rise,
	output rd_beat_t               rd,
	// Memory pins
	output logic [CLK_PAIRS-1:0]   mem_clk,
	output logic [CLK_PAIRS-1:0]   mem_clk_n,
	output logic [RANKS-1:0]       rank_sel_n,
	output logic [ADDR_W-1:0]      mux_addr,
	output logic [BANK_W-1:0]      bank_sel,
	output logic                   row_strobe_n,
	output logic                   col_strobe_n,
	output logic                   write_en_n,
	output logic [DQ_W-1:0]        dq_o,
	output logic [DQ_W-1:0]        dq_oe_n,
	input  wire logic [DQ_W-1:0]   dq_i,
	output logic [LANES-1:0]       byte_mask,
	output logic [LANES-1:0]       dqs_o,
	output logic [LANES-1:0]       dqs_n_o,
	output logic [LANES-1:0]       dqs_oe_n,
	input  wire logic [LANES-1:0]  dqs_i,
	output logic [RANKS-1:0]       clk_en,
	output logic [RANKS-1:0]       term_ctl
);

	logic [1:0]           div_r;	// Half-period counter
	logic                 phase_r;	// Memory clock level
	logic                 fall_now;	// Next edge lowers the clock
	logic                 rise_now;	// Next edge raises the clock
	logic                 wr_act_r;	// Write burst on the pins
	logic [DQ_W-1:0]      fall_d_r;	// Falling beat held for half period
	logic [LANES-1:0]     fall_m_r;	// Falling masks held
	logic [LANES-1:0]     dqs_s1_r;	// Strobe synchroniser, first stage
	logic [LANES-1:0]     dqs_s2_r;	// Strobe synchroniser, second stage
	logic [LANES-1:0]     dqs_s3_r;	// Previous synchronised strobe
	logic [DQ_W-1:0]      dq_s1_r;	// Data synchroniser, first stage
	logic [DQ_W-1:0]      dq_s2_r;	// Data synchroniser, second stage
	logic [DQ_W-1:0]      rise_cap_r;	// Beat taken at strobe rise
	logic [2:0]           enc;	// Row, col, we encoding

	// Command to row/col/we levels; the idle lines are driven high directly
	function automatic logic [2:0] cmd_pins(input cmd_t c);
		return 3'(c);
	endfunction : cmd_pins

	assign rise_now = (div_r == CLK_HALF_CYC) && !phase_r;
	assign fall_now = (div_r == CLK_HALF_CYC) && phase_r;
	assign enc      = cmd_pins(req.cmd);

	// Clock divider; all pairs toggle together, complement opposite
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			div_r   <= 2'h1;
			phase_r <= 1'b0;
		end else if (div_r == CLK_HALF_CYC) begin
			div_r   <= 2'h1;
			phase_r <= !phase_r;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end

	// Differential clock outputs from flops, true and complement opposite
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mem_clk   <= '0;
			mem_clk_n <= '1;
			clk_rise  <= 1'b0;
		end else begin
			mem_clk   <= {CLK_PAIRS{phase_r ^ (div_r == CLK_HALF_CYC)}};	// see RULE_01
			mem_clk_n <= {CLK_PAIRS{!(phase_r ^ (div_r == CLK_HALF_CYC))}};
			clk_rise  <= rise_now;
		end
	end

	// Command lines change on the falling clock so the memory sees them stable at the rise
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rank_sel_n   <= RST_SEL_N;
			mux_addr     <= RST_ADDR;
			bank_sel     <= RST_BANK;
			row_strobe_n <= 1'b1;
			col_strobe_n <= 1'b1;
			write_en_n   <= 1'b1;
		end else if (fall_now) begin
			if (req.valid) begin
				rank_sel_n   <= ~(4'h1 << req.rank);	// see RULE_02
				mux_addr     <= req.addr;	// see RULE_03
				bank_sel     <= req.bank;	// see RULE_04
				row_strobe_n <= enc[2];	// see RULE_05
				col_strobe_n <= enc[1];	// see RULE_12
				write_en_n   <= enc[0];
			end else begin
				// Deselect: no rank, lines idle high
				rank_sel_n   <= RST_SEL_N;	// see RULE_12
				row_strobe_n <= 1'b1;
				col_strobe_n <= 1'b1;
				write_en_n   <= 1'b1;
			end
		end
	end

	// Clock enable and termination per rank
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			clk_en   <= RST_CKE;
			term_ctl <= RST_ODT;
		end else if (fall_now) begin
			clk_en   <= cke_req;	// see RULE_09
			term_ctl <= odt_req;	// see RULE_10
		end
	end

	// Write path: rising beat at clock rise, falling beat at clock fall
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_act_r  <= 1'b0;
			fall_d_r  <= '0;
			fall_m_r  <= '0;
			dq_o      <= '0;
			dq_oe_n   <= '1;
			byte_mask <= '0;
			dqs_o     <= '0;
			dqs_n_o   <= '1;
			dqs_oe_n  <= '1;
		end else if (rise_now) begin
			wr_act_r <= wr.valid;
			fall_d_r <= wr.rise_d;
			fall_m_r <= wr.rise_m;
			if (wr.valid) begin
				dq_o      <= wr.rise_d;	// see RULE_06
				byte_mask <= wr.rise_m;	// see RULE_07
				fall_d_r  <= wr.fall_d;
				fall_m_r  <= wr.fall_m;
			end
			dq_oe_n  <= {DQ_W{!wr.valid}};
			dqs_oe_n <= {LANES{!wr.valid}};	// see RULE_08
			dqs_o    <= {LANES{wr.valid}};
			dqs_n_o  <= {LANES{!wr.valid}};
		end else if (fall_now) begin
			if (wr_act_r) begin
				dq_o      <= fall_d_r;
				byte_mask <= fall_m_r;
			end
			dqs_o   <= '0;
			dqs_n_o <= '1;
		end
	end

	// Read capture: strobe and data pass two flops before use
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dqs_s1_r <= '0;
			dqs_s2_r <= '0;
			dqs_s3_r <= '0;
			dq_s1_r  <= '0;
			dq_s2_r  <= '0;
		end else begin
			dqs_s1_r <= dqs_i;
			dqs_s2_r <= dqs_s1_r;
			dqs_s3_r <= dqs_s2_r;
			dq_s1_r  <= dq_i;
			dq_s2_r  <= dq_s1_r;
		end
	end

	// Lane 0 strobe marks beats for the whole word; reads only while expected
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rise_cap_r <= '0;
			rd         <= '0;
		end else begin
			rd.valid <= 1'b0;
			if (rd_en && dqs_s2_r[0] && !dqs_s3_r[0]) begin
				rise_cap_r <= dq_s2_r;	// see RULE_08
			end
			if (rd_en && !dqs_s2_r[0] && dqs_s3_r[0]) begin
				rd.valid  <= 1'b1;	// see RULE_06
				rd.rise_d <= rise_cap_r;
				rd.fall_d <= dq_s2_r;
			end
		end
	end

	// Only one rank selected at a time
	a_one_rank_sel: assert property (@(posedge mclk) disable iff (!rst_n)	// see RULE_02
		$countones(~rank_sel_n) <= 1)
		else $error("more than one rank selected");

	// Request on a falling edge reaches the select pin next cycle
	a_sel_follows_req: assert property (@(posedge mclk) disable iff (!rst_n)	// see RULE_02
		(fall_now && req.valid) |=> !rank_sel_n[$past(req.rank)])
		else $error("addressed rank not selected");

	// Clock pairs stay complementary
	a_clk_pairs_diff: assert property (@(posedge mclk) disable iff (!rst_n)	// see RULE_01
		mem_clk == ~mem_clk_n)
		else $error("clock pair not complementary");

	// Memory clock has period of four mclk cycles
	a_clk_period: assert property (@(posedge mclk) disable iff (!rst_n)	// see RULE_01
		$rose(mem_clk[0]) |=> !$rose(mem_clk[0]) ##1 !$rose(mem_clk[0]) ##1 !$rose(mem_clk[0])
			##1 $rose(mem_clk[0]))
		else $error("memory clock period wrong");

	// Row strobe and rank select pins hold across the memory clock rise
	a_cmd_stable: assert property (@(posedge mclk) disable iff (!rst_n)	// see RULE_05
		$rose(mem_clk[0]) |-> $stable(row_strobe_n) && $stable(rank_sel_n))
		else $error("command changed at clock rise");

	// Deselect leaves all command lines high
	a_idle_lines: assert property (@(posedge mclk) disable iff (!rst_n)	// see RULE_12
		(rank_sel_n == RST_SEL_N) |-> (row_strobe_n && col_strobe_n && write_en_n))
		else $error("command lines active with no rank");

	// Address pins carry the request's address
	a_addr_bank: assert property (@(posedge mclk) disable iff (!rst_n)	// see RULE_03
		(fall_now && req.valid) |=> mux_addr == $past(req.addr) && bank_sel == $past(req.bank))
		else $error("address or bank not driven");

	// Written data drives the bus with strobes on
	a_wr_drive: assert property (@(posedge mclk) disable iff (!rst_n)	// see RULE_06
		(rise_now && wr.valid) |=> dq_oe_n == '0 && dqs_oe_n == '0 && dq_o == $past(wr.rise_d))
		else $error("write beat not driven");

	// Clock enable follows request at the falling edge
	a_cke_odt: assert property (@(posedge mclk) disable iff (!rst_n)	// see RULE_09
		fall_now |=> clk_en == $past(cke_req) && term_ctl == $past(odt_req))
		else $error("clock enable or termination late");

endmodule : ddr2_chan

// file: rtl/ddr2_dual_channel_pin_interface.sv
`timescale 1ns/100ps
// What this block does
// RULE_01: Six differential clock pairs per channel
// RULE_02: Select only the addressed rank, active low
// RULE_03: Fourteen-bit multiplexed row/column address
// RULE_04: Three-bit bank select, eight banks
// RULE_05: Row/col/write lines encode each command
// RULE_06: 64-bit double-rate bidirectional data bus
// RULE_07: Byte masks block writing of lanes
// RULE_08: Differential strobes accompany data, both directions; reads sample only the true strobe of lane 0
// RULE_09: Per-rank clock enable for power states
// RULE_10: Four termination controls per channel
// RULE_11: Two identical independent channels
// RULE_12: Standard command table; deselect via selects
module ddr2_dual_channel_pin_interface
	import ddr2_pin_pkg::*;
(
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// Controller side, index is channel
	input  wire cmd_req_t             req      [2],
	input  wire wr_beat_t             wr       [2],
	input  wire logic [RANKS-1:0]     cke_req  [2],
	input  wire logic [RANKS-1:0]     odt_req  [2],
	input  wire logic                 rd_en    [2],
	output logic                      clk_rise [2],
	output rd_beat_t                  rd       [2],
	// Channel 0 pins
	output logic [CLK_PAIRS-1:0]      chan0_mem_clk,
	output logic [CLK_PAIRS-1:0]      chan0_mem_clk_n,
	output logic [RANKS-1:0]          chan0_rank_sel_n,
	output logic [ADDR_W-1:0]         chan0_mux_addr,
	output logic [BANK_W-1:0]         chan0_bank_sel,
	output logic                      chan0_row_strobe_n,
	output logic                      chan0_col_strobe_n,
	output logic                      chan0_write_en_n,
	output logic [DQ_W-1:0]           chan0_dq_o,
	output logic [DQ_W-1:0]           chan0_dq_oe_n,
	input  wire logic [DQ_W-1:0]      chan0_dq_i,
	output logic [LANES-1:0]          chan0_byte_mask,
	output logic [LANES-1:0]          chan0_data_strobe_o,
	output logic [LANES-1:0]          chan0_data_strobe_n_o,
	output logic [LANES-1:0]          chan0_data_strobe_oe_n,
	input  wire logic [LANES-1:0]     chan0_data_strobe_i,
	output logic [RANKS-1:0]          chan0_clk_en,
	output logic [RANKS-1:0]          chan0_term_ctl,
	// Channel 1 pins
	output logic [CLK_PAIRS-1:0]      chan1_mem_clk,
	output logic [CLK_PAIRS-1:0]      chan1_mem_clk_n,
	output logic [RANKS-1:0]          chan1_rank_sel_n,
	output logic [ADDR_W-1:0]         chan1_mux_addr,
	output logic [BANK_W-1:0]         chan1_bank_sel,
	output logic                      chan1_row_strobe_n,
	output logic                      chan1_col_strobe_n,
	output logic                      chan1_write_en_n,
	output logic [DQ_W-1:0]           chan1_dq_o,
	output logic [DQ_W-1:0]           chan1_dq_oe_n,
	input  wire logic [DQ_W-1:0]      chan1_dq_i,
	output logic [LANES-1:0]          chan1_byte_mask,
	output logic [LANES-1:0]          chan1_data_strobe_o,
	output logic [LANES-1:0]          chan1_data_strobe_n_o,
	output logic [LANES-1:0]          chan1_data_strobe_oe_n,
	input  wire logic [LANES-1:0]     chan1_data_strobe_i,
	output logic [RANKS-1:0]          chan1_clk_en,
	output logic [RANKS-1:0]          chan1_term_ctl
);

	// Two separate instances; only clock and reset are shared, so one channel never stalls the other
	ddr2_chan u_chan0 (	// see RULE_11
		.mclk         (mclk),
		.rst_n        (rst_n),
		.req          (req[0]),
		.wr           (wr[0]),
		.cke_req      (cke_req[0]),
		.odt_req      (odt_req[0]),
		.rd_en        (rd_en[0]),
		.clk_rise     (clk_rise[0]),
		.rd           (rd[0]),
		.mem_clk      (chan0_mem_clk),
		.mem_clk_n    (chan0_mem_clk_n),
		.rank_sel_n   (chan0_rank_sel_n),
		.mux_addr     (chan0_mux_addr),
		.bank_sel     (chan0_bank_sel),
		.row_strobe_n (chan0_row_strobe_n),
		.col_strobe_n (chan0_col_strobe_n),
		.write_en_n   (chan0_write_en_n),
		.dq_o         (chan0_dq_o),
		.dq_oe_n      (chan0_dq_oe_n),
		.dq_i         (chan0_dq_i),
		.byte_mask    (chan0_byte_mask),
		.dqs_o        (chan0_data_strobe_o),
		.dqs_n_o      (chan0_data_strobe_n_o),
		.dqs_oe_n     (chan0_data_strobe_oe_n),
		.dqs_i        (chan0_data_strobe_i),
		.clk_en       (chan0_clk_en),
		.term_ctl     (chan0_term_ctl)
	);

	// Second channel, same logic
	ddr2_chan u_chan1 (	// see RULE_11
		.mclk         (mclk),
		.rst_n        (rst_n),
		.req          (req[1]),
		.wr           (wr[1]),
		.cke_req      (cke_req[1]),
		.odt_req      (odt_req[1]),
		.rd_en        (rd_en[1]),
		.clk_rise     (clk_rise[1]),
		.rd           (rd[1]),
		.mem_clk      (chan1_mem_clk),
		.mem_clk_n    (chan1_mem_clk_n),
		.rank_sel_n   (chan1_rank_sel_n),
		.mux_addr     (chan1_mux_addr),
		.bank_sel     (chan1_bank_sel),
		.row_strobe_n (chan1_row_strobe_n),
		.col_strobe_n (chan1_col_strobe_n),
		.write_en_n   (chan1_write_en_n),
		.dq_o         (chan1_dq_o),
		.dq_oe_n      (chan1_dq_oe_n),
		.dq_i         (chan1_dq_i),
		.byte_mask    (chan1_byte_mask),
		.dqs_o        (chan1_data_strobe_o),
		.dqs_n_o      (chan1_data_strobe_n_o),
		.dqs_oe_n     (chan1_data_strobe_oe_n),
		.dqs_i        (chan1_data_strobe_i),
		.clk_en       (chan1_clk_en),
		.term_ctl     (chan1_term_ctl)
	);

endmodule : ddr2_dual_channel_pin_interface

// file: bench/ddr2_mem_model.sv
`timescale 1ns/100ps
// Behavioural memory ranks: answer a read burst with their own strobe clock
module ddr2_mem_model
	import ddr2_pin_pkg::*;
(
	// Burst trigger from the bench
	input  wire logic            go,
	input  wire logic [DQ_W-1:0] beat_a,
	input  wire logic [DQ_W-1:0] beat_b,
	// Memory side of the data lanes
	output logic [DQ_W-1:0]      dq,
	output logic [LANES-1:0]     dqs
);
	localparam real HALF = 62.5;	// Half of the 125 ns strobe period

	// Quiet lanes until the first burst
	initial begin
		dq  = '0;
		dqs = '0;
	end

	// Preamble low, beat A while high, beat B while low, then release
	always @(posedge go) begin
		#(HALF / 3.0);	// Strobe phase unrelated to mclk
		dq  = ~dq;
		dqs = '0;
		#HALF;
		dq  = beat_a;
		dqs = '1;
		#HALF;
		dq  = beat_b;
		dqs = '0;
		#HALF;
		// Released lines float away from the last value; the host must stop capturing
		dq  = ~beat_b;
		dqs = '1;
	end
endmodule : ddr2_mem_model

// file: bench/tb.sv
`timescale 1ns/100ps
// Self-checking bench for the two-channel memory pin block
module tb
	import ddr2_pin_pkg::*;
;
	logic mclk  = 1'b0;	// 200 MHz core clock
	logic rst_n = 1'b0;	// Synchronous reset, active low
	// Controller side
	cmd_req_t         req     [2];
	wr_beat_t         wr      [2];
	logic [RANKS-1:0] cke_req [2];
	logic [RANKS-1:0] odt_req [2];
	logic             rd_en   [2];
	logic             clk_rise[2];
	rd_beat_t         rd      [2];
	// Partner control and lines
	logic             go      [2];
	logic [DQ_W-1:0]  beat_a  [2];
	logic [DQ_W-1:0]  beat_b  [2];
	logic [DQ_W-1:0]  p_dq    [2];
	logic [LANES-1:0] p_dqs   [2];
	// Pins
	logic [CLK_PAIRS-1:0] chan0_mem_clk, chan0_mem_clk_n, chan1_mem_clk, chan1_mem_clk_n;
	logic [RANKS-1:0]     chan0_rank_sel_n, chan1_rank_sel_n, chan0_clk_en, chan1_clk_en;
	logic [RANKS-1:0]     chan0_term_ctl, chan1_term_ctl;
	logic [ADDR_W-1:0]    chan0_mux_addr, chan1_mux_addr;
	logic [BANK_W-1:0]    chan0_bank_sel, chan1_bank_sel;
	logic                 chan0_row_strobe_n, chan0_col_strobe_n, chan0_write_en_n;
	logic                 chan1_row_strobe_n, chan1_col_strobe_n, chan1_write_en_n;
	logic [DQ_W-1:0]      chan0_dq_o, chan0_dq_oe_n, chan0_dq_i;
	logic [DQ_W-1:0]      chan1_dq_o, chan1_dq_oe_n, chan1_dq_i;
	logic [LANES-1:0]     chan0_byte_mask, chan0_data_strobe_o, chan0_data_strobe_n_o;
	logic [LANES-1:0]     chan0_data_strobe_oe_n, chan0_data_strobe_i, chan1_byte_mask;
	logic [LANES-1:0]     chan1_data_strobe_o, chan1_data_strobe_n_o;
	logic [LANES-1:0]     chan1_data_strobe_oe_n, chan1_data_strobe_i;
	int failures   = 0;	// Mismatch count
	int num_checks = 0;	// Comparison count
	cmd_t cmds [7] = '{CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_NOP};

	// Wire level: whoever has its enable low wins, otherwise the memory side
	assign chan0_dq_i = (chan0_dq_oe_n & p_dq[0]) | (~chan0_dq_oe_n & chan0_dq_o);
	assign chan1_dq_i = (chan1_dq_oe_n & p_dq[1]) | (~chan1_dq_oe_n & chan1_dq_o);
	assign chan0_data_strobe_i = (chan0_data_strobe_oe_n & p_dqs[0])
		| (~chan0_data_strobe_oe_n & chan0_data_strobe_o);
	assign chan1_data_strobe_i = (chan1_data_strobe_oe_n & p_dqs[1])
		| (~chan1_data_strobe_oe_n & chan1_data_strobe_o);

	// Core clock
	always #2.5 mclk = ~mclk;

	ddr2_dual_channel_pin_interface ddr2_dual_channel_pin_interface_i (
		.mclk, .rst_n, .req, .wr, .cke_req, .odt_req, .rd_en, .clk_rise, .rd,
		.chan0_mem_clk, .chan0_mem_clk_n, .chan0_rank_sel_n, .chan0_mux_addr, .chan0_bank_sel,
		.chan0_row_strobe_n, .chan0_col_strobe_n, .chan0_write_en_n, .chan0_dq_o,
		.chan0_dq_oe_n, .chan0_dq_i, .chan0_byte_mask, .chan0_data_strobe_o,
		.chan0_data_strobe_n_o, .chan0_data_strobe_oe_n, .chan0_data_strobe_i,
		.chan0_clk_en, .chan0_term_ctl,
		.chan1_mem_clk, .chan1_mem_clk_n, .chan1_rank_sel_n, .chan1_mux_addr, .chan1_bank_sel,
		.chan1_row_strobe_n, .chan1_col_strobe_n, .chan1_write_en_n, .chan1_dq_o,
		.chan1_dq_oe_n, .chan1_dq_i, .chan1_byte_mask, .chan1_data_strobe_o,
		.chan1_data_strobe_n_o, .chan1_data_strobe_oe_n, .chan1_data_strobe_i,
		.chan1_clk_en, .chan1_term_ctl
	);

	ddr2_mem_model mem0 (.go(go[0]), .beat_a(beat_a[0]), .beat_b(beat_b[0]),
		.dq(p_dq[0]), .dqs(p_dqs[0]));
	ddr2_mem_model mem1 (.go(go[1]), .beat_a(beat_a[1]), .beat_b(beat_b[1]),
		.dq(p_dq[1]), .dqs(p_dqs[1]));

	// Compare and count; values are zero-extended to 64 bits
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Verdict, the only way out of the run
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	// Hold reset six cycles and look at the idle pin levels
	task automatic do_reset;
		@(negedge mclk);
		rst_n = 1'b0;
		repeat (6) @(negedge mclk);
		check(chan0_rank_sel_n, RST_SEL_N);
		check({chan0_row_strobe_n, chan0_col_strobe_n, chan0_write_en_n}, 3'h7);
		check({chan0_mux_addr, chan0_bank_sel}, {RST_ADDR, RST_BANK});
		check({chan0_clk_en, chan1_clk_en}, {RST_CKE, RST_CKE});
		check({chan0_term_ctl, chan1_term_ctl}, {RST_ODT, RST_ODT});
		check({chan0_mem_clk, chan0_mem_clk_n, chan1_mem_clk, chan1_mem_clk_n}, 24'h03f03f);
		check({chan0_data_strobe_oe_n, chan1_data_strobe_oe_n}, 16'hffff);
		check(chan0_dq_oe_n, '1);
		check(chan1_dq_oe_n, '1);
		rst_n = 1'b1;
		$display("test reset done");
	endtask : do_reset

	// Memory clock is mclk/4, pairs complementary and in step
	task automatic test_clock;
		int rises;
		int pulses;
		logic prev;
		rises  = 0;
		pulses = 0;
		prev   = chan0_mem_clk[0];
		repeat (40) begin
			@(negedge mclk);
			check(chan0_mem_clk ^ chan0_mem_clk_n, 6'h3f);
			check(chan0_mem_clk, {6{chan0_mem_clk[0]}});
			check(chan1_mem_clk ^ chan1_mem_clk_n, 6'h3f);
			check({chan1_mem_clk, clk_rise[1]}, {chan0_mem_clk, clk_rise[0]});
			if (chan0_mem_clk[0] === 1'b1 && prev === 1'b0) rises++;
			if (clk_rise[0] === 1'b1) pulses++;
			prev = chan0_mem_clk[0];
		end
		check(rises, 10);
		check(pulses, 10);
		$display("test clock done");
	endtask : test_clock

	// Every command on both channels at once, different ranks, boundary fields
	task automatic test_cmds;
		for (int i = 0; i < 7; i++) begin
			@(negedge mclk);
			req[0] = {1'b1, cmds[i], 2'(i), 3'(7 - i), (i == 6) ? 14'h3fff : 14'(i)};
			req[1] = {1'b1, cmds[6 - i], 2'(3 - i), 3'(i), 14'h2aaa ^ 14'(i)};
			repeat (8) @(negedge mclk);
			check({chan0_rank_sel_n, chan0_row_strobe_n, chan0_col_strobe_n, chan0_write_en_n,
				chan0_bank_sel, chan0_mux_addr}, {~(4'h1 << (i % 4)), cmds[i], 3'(7 - i),
				(i == 6) ? 14'h3fff : 14'(i)});
			check({chan1_rank_sel_n, chan1_row_strobe_n, chan1_col_strobe_n, chan1_write_en_n,
				chan1_bank_sel, chan1_mux_addr}, {~(4'h8 >> (i % 4)), cmds[6 - i], 3'(i),
				14'h2aaa ^ 14'(i)});
		end
		@(negedge mclk);
		req[0].valid = 1'b0;
		req[1].valid = 1'b0;
		repeat (8) @(negedge mclk);
		check({chan0_rank_sel_n, chan1_rank_sel_n}, 8'hff);
		$display("test commands done");
	endtask : test_cmds

	// One write beat pair with lane masks on channel 0, its mirror image on channel 1
	task automatic test_write;
		int n;
		@(negedge mclk);
		wr[0] = {1'b1, 64'h0123456789abcdef, 64'hfedcba9876543210, 8'h5a, 8'ha5};
		wr[1] = {1'b1, 64'hfedcba9876543210, 64'h0123456789abcdef, 8'ha5, 8'h5a};
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (chan0_dq_oe_n[0] !== 1'b0 && n < 6);
		wr[0].valid = 1'b0;
		wr[1].valid = 1'b0;
		check(chan0_dq_oe_n, 64'h0);
		check(chan0_dq_o, 64'h0123456789abcdef);
		check(chan0_byte_mask, 8'h5a);
		check(chan0_data_strobe_oe_n, 8'h00);
		check({chan0_data_strobe_o, chan0_data_strobe_n_o}, 16'hff00);
		check(chan1_dq_oe_n, 64'h0);
		check(chan1_dq_o, 64'hfedcba9876543210);
		check({chan1_byte_mask, chan1_data_strobe_oe_n}, 16'ha500);
		check({chan1_data_strobe_o, chan1_data_strobe_n_o}, 16'hff00);
		repeat (2) @(negedge mclk);
		check(chan0_dq_o, 64'hfedcba9876543210);
		check(chan0_byte_mask, 8'ha5);
		check({chan0_data_strobe_o, chan0_data_strobe_n_o}, 16'h00ff);
		check(chan1_dq_o, 64'h0123456789abcdef);
		check(chan1_byte_mask, 8'h5a);
		check({chan1_data_strobe_o, chan1_data_strobe_n_o}, 16'h00ff);
		repeat (2) @(negedge mclk);
		check({chan0_dq_oe_n[0], chan0_data_strobe_oe_n}, 9'h1ff);
		check({chan1_dq_oe_n[0], chan1_data_strobe_oe_n}, 9'h1ff);
		$display("test write done");
	endtask : test_write

	// Read burst from the partner, then a whole second burst refused with capture off
	task automatic test_read(input int c, input logic [63:0] a, input logic [63:0] b);
		int n;
		@(negedge mclk);
		rd_en[c]  = 1'b1;
		beat_a[c] = a;
		beat_b[c] = b;
		go[c]     = 1'b1;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (rd[c].valid !== 1'b1 && n < 80);
		check(rd[c].valid, 1'b1);
		check(rd[c].rise_d, a);
		check(rd[c].fall_d, b);
		rd_en[c] = 1'b0;
		go[c]    = 1'b0;
		@(negedge mclk);
		check(rd[c].valid, 1'b0);
		// The model ignores go until its first burst has ended, so wait that out first
		repeat (10) @(negedge mclk);
		go[c] = 1'b1;
		n = 0;
		repeat (60) begin
			@(negedge mclk);
			if (rd[c].valid === 1'b1) n++;
		end
		check(n, 0);
		$display("test read channel %0d done", c);
	endtask : test_read

	// Per-rank clock enables and termination, distinct on each channel
	task automatic test_power;
		@(negedge mclk);
		cke_req[0] = 4'ha;
		odt_req[0] = 4'h5;
		cke_req[1] = 4'h5;
		odt_req[1] = 4'ha;
		repeat (8) @(negedge mclk);
		check(chan0_clk_en, 4'ha);
		check(chan0_term_ctl, 4'h5);
		check({chan1_clk_en, chan1_term_ctl}, 8'h5a);
		$display("test power done");
	endtask : test_power

	// Main sequence; the second reset comes with enables still requested
	initial begin
		for (int c = 0; c < 2; c++) begin
			req[c]     = '0;
			wr[c]      = '0;
			cke_req[c] = '0;
			odt_req[c] = '0;
			rd_en[c]   = 1'b0;
			go[c]      = 1'b0;
			beat_a[c]  = '0;
			beat_b[c]  = '0;
		end
		do_reset();
		test_clock();
		test_cmds();
		test_write();
		test_read(0, 64'h1122334455667788, 64'h99aabbccddeeff00);
		test_read(1, 64'hf0e1d2c3b4a59687, 64'h0f1e2d3c4b5a6978);
		test_power();
		do_reset();
		complete_run();
	end

	// Watchdog: the tests need about 350 cycles
	initial begin
		#100us;
		failures++;
		complete_run();
	end
endmodule : tb
